// file: clksrc_defs.svh
// Purpose: constants of the programmable clock command source
// Assumes: 20 MHz system clock
// Notes:   command codes, answers and timing counts
`ifndef CLKSRC_DEFS_SVH
`define CLKSRC_DEFS_SVH

// ==========================================================
// command and answer codes
`define CMD_FREQ_ONE     8'h00
`define CMD_FREQ_TWO     8'h02
`define CMD_FREQ_FOUR    8'h04
`define CMD_FREQ_EIGHT   8'h06
`define CMD_FREQ_SIXTEEN 8'h08
`define CMD_QUERY        8'h0a
`define ANS_OK           8'h00
`define ANS_BAD          8'h01
`define ANS_BUSY         8'h02

// ==========================================================
// rates
`define CLK_MHZ      20
`define BASE_MHZ     16
`define REF_HZ       32768
`define CLK_HZ       (`CLK_MHZ * 1000000)
`define REF_GCD      8
`define REF_STEP     (`REF_HZ / `REF_GCD)
`define REF_MOD      (`CLK_HZ / `REF_GCD)
`define BAUD_RATE    4800
`define BAUD_DIV(m)  (((m) * 1000000) / `BAUD_RATE)
`define SEL_RESET    3'h4
`define SEL_DEFAULT  3'h0
// longest wait to answer: one whole answer frame at 1 MHz
`define REPLY_MAX    16'ha410

`endif

// file: clksrc_pkg.sv
// Purpose: types of the programmable clock command source
// Assumes: nothing
// Notes:   one-hot controller states
package clksrc_pkg;

	// ==========================================================
	// controller states
	typedef enum logic [3:0] {
		ST_INIT  = 4'b0001,
		ST_IDLE  = 4'b0010,
		ST_EXEC  = 4'b0100,
		ST_REPLY = 4'b1000
	} ctrl_state_t;

	typedef logic [2:0] freq_sel_t; // 0..4 = 1,2,4,8,16 MHz

endpackage : clksrc_pkg

// file: clksrc_core.sv
// Purpose: clock source driven by one-byte commands over uart or spi
// Assumes: inputs synchronous to CLOCK; persistent memory outside
// Notes:   clock outputs are one-cycle enable pulses at average rate
// Behaviour
// - output clock selectable among 1, 2, 4, 8 and 16 MHz.
// - a 32.768 kHz reference pulse runs always, unaffected by selection.
// - after reset run at 16 MHz base, then apply the stored command.
// - every accepted frequency selection is written to persistent memory.
// - initial memory contents give a 1 MHz output.
// - uart runs at 4800 baud, one stop bit, no parity.
// - spi slave, active low select, clock idles low, changes on rise, samples on fall.
// - every command is exactly one byte on either interface.
// - codes 00,02,04,06,08 select 1,2,4,8,16 MHz.
// - on spi the host polls with 0a and reads status next byte.
// - on uart one answer byte follows each executed command.
// - answers: 00 done, 01 unknown command, 02 still executing.
// - uart baud counters reload whenever the output frequency changes.
`timescale 1ns/1ps
`include "clksrc_defs.svh"

module clksrc_core (
	input  wire logic       CLOCK,
	input  wire logic       RST_N,
	input  wire logic       UART_RXD,
	output logic            UART_TXD,
	input  wire logic       SPI_CS_N,
	input  wire logic       SPI_SCLK,
	input  wire logic       SPI_MOSI,
	output logic            SPI_MISO,
	output logic            SPI_MISO_OE,
	input  wire logic [7:0] NV_RD_DATA,
	input  wire logic       NV_READY,
	output logic            NV_WR_EN,
	output logic [7:0]      NV_WR_DATA,
	output logic            FREQ_TICK,
	output logic            REF_TICK,
	output logic [2:0]      FREQ_SEL,
	output logic            BUSY
);
	// ==========================================================
	// declarations
	clksrc_pkg::ctrl_state_t state_reg;
	clksrc_pkg::freq_sel_t   sel_reg;
	logic [4:0]  base_acc_reg;
	logic [4:0]  div_cnt_reg;
	logic [21:0] ref_acc_reg;
	logic [7:0]  status_reg;
	logic [7:0]  cmd_reg;
	logic        cmd_uart_reg;
	logic        base_tick;
	logic        sel_chg;
	logic [11:0] baud_div;
	logic [11:0] rx_cnt_reg;
	logic [3:0]  rx_bit_reg;
	logic        rx_act_reg;
	logic [7:0]  rx_sh_reg;
	logic        rx_done_reg;
	logic [11:0] tx_cnt_reg;
	logic [3:0]  tx_bit_reg;
	logic [9:0]  tx_sh_reg;
	logic        tx_start;
	logic        sclk_prev_reg;
	logic        cs_prev_reg;
	logic [2:0]  spi_bit_reg;
	logic [7:0]  spi_rx_reg;
	logic [7:0]  spi_tx_reg;
	logic        spi_done_reg;
	logic        spi_rise;
	logic        spi_fall;
	logic        cmd_in;
	logic [7:0]  cmd_byte;
	logic        dec_ok;
	clksrc_pkg::freq_sel_t dec_sel;
	logic [15:0] reply_wait_reg;

	// divider ratio 16/f is a power of two: 16 >> sel
	function automatic logic [4:0] div_of(clksrc_pkg::freq_sel_t s);
		div_of = 5'h10 >> s;
	endfunction : div_of

	// ==========================================================
	// clock generation
	// 16 MHz base: 16 steps modulo 20 per cycle
	// one bit wider so the sum cannot wrap before the compare
	assign base_tick = ({1'b0, base_acc_reg} + 6'(`BASE_MHZ))
	                   >= 6'(`CLK_MHZ);
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			base_acc_reg <= 5'h00;
		else if (base_tick)
			base_acc_reg <= base_acc_reg + 5'(`BASE_MHZ) - 5'(`CLK_MHZ);
		else
			base_acc_reg <= base_acc_reg + 5'(`BASE_MHZ);
	end

	// divide base ticks down to the selected output rate
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			div_cnt_reg <= 5'h00;
			FREQ_TICK   <= 1'b0;
		end else begin
			FREQ_TICK <= 1'b0;
			if (sel_chg)
				div_cnt_reg <= 5'h00;
			else if (base_tick) begin
				if (div_cnt_reg >= div_of(sel_reg) - 5'h01) begin
					div_cnt_reg <= 5'h00;
					FREQ_TICK   <= 1'b1;
				end else
					div_cnt_reg <= div_cnt_reg + 5'h01;
			end
		end
	end

	// free running reference, never touched by selection
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ref_acc_reg <= 22'h000000;
			REF_TICK    <= 1'b0;
		end else if (ref_acc_reg + 22'(`REF_STEP) >= 22'(`REF_MOD)) begin
			ref_acc_reg <= ref_acc_reg + 22'(`REF_STEP) - 22'(`REF_MOD);
			REF_TICK    <= 1'b1;
		end else begin
			ref_acc_reg <= ref_acc_reg + 22'(`REF_STEP);
			REF_TICK    <= 1'b0;
		end
	end

	// baud divisor in output-clock ticks for the current selection
	always_comb begin
		case (sel_reg)
			3'h0:    baud_div = 12'(`BAUD_DIV(1));
			3'h1:    baud_div = 12'(`BAUD_DIV(2));
			3'h2:    baud_div = 12'(`BAUD_DIV(4));
			3'h3:    baud_div = 12'(`BAUD_DIV(8));
			default: baud_div = 12'(`BAUD_DIV(16));
		endcase
	end

	// ==========================================================
	// uart receiver, 8N1, timed from the output clock
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rx_act_reg  <= 1'b0;
			rx_cnt_reg  <= 12'h000;
			rx_bit_reg  <= 4'h0;
			rx_sh_reg   <= 8'h00;
			rx_done_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			if (sel_chg)
				rx_cnt_reg <= baud_div;
			if (!rx_act_reg) begin
				if (!UART_RXD) begin
					rx_act_reg <= 1'b1;
					rx_bit_reg <= 4'h0;
					rx_cnt_reg <= baud_div >> 1;
				end
			end else if (FREQ_TICK && !sel_chg) begin
				if (rx_cnt_reg != 12'h000)
					rx_cnt_reg <= rx_cnt_reg - 12'h001;
				else begin
					rx_cnt_reg <= baud_div;
					rx_bit_reg <= rx_bit_reg + 4'h1;
					if (rx_bit_reg == 4'h0 && UART_RXD)
						rx_act_reg <= 1'b0; // false start
					else if (rx_bit_reg == 4'h9) begin
						rx_act_reg  <= 1'b0;
						rx_done_reg <= UART_RXD;
					end else if (rx_bit_reg != 4'h0)
						rx_sh_reg <= {UART_RXD, rx_sh_reg[7:1]};
				end
			end
		end
	end

	// uart transmitter: start, 8 data lsb first, one stop
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tx_sh_reg  <= 10'h3ff;
			tx_cnt_reg <= 12'h000;
			tx_bit_reg <= 4'h0;
		end else if (tx_start) begin
			tx_sh_reg  <= {1'b1, status_reg, 1'b0};
			tx_cnt_reg <= baud_div;
			tx_bit_reg <= 4'ha;
		end else if (sel_chg)
			tx_cnt_reg <= baud_div;
		else if (FREQ_TICK && tx_bit_reg != 4'h0) begin
			if (tx_cnt_reg != 12'h000)
				tx_cnt_reg <= tx_cnt_reg - 12'h001;
			else begin
				tx_cnt_reg <= baud_div;
				tx_bit_reg <= tx_bit_reg - 4'h1;
				tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
			end
		end
	end
	assign UART_TXD = tx_sh_reg[0];

	// ==========================================================
	// spi slave: data changes on the rise, is sampled on the fall
	assign spi_rise = SPI_SCLK && !sclk_prev_reg && !SPI_CS_N;
	assign spi_fall = !SPI_SCLK && sclk_prev_reg && !SPI_CS_N;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg   <= 1'b1;
			spi_bit_reg   <= 3'h0;
			spi_rx_reg    <= 8'h00;
			spi_tx_reg    <= 8'h00;
			spi_done_reg  <= 1'b0;
		end else begin
			sclk_prev_reg <= SPI_SCLK;
			cs_prev_reg   <= SPI_CS_N;
			spi_done_reg  <= 1'b0;
			if (SPI_CS_N)
				spi_bit_reg <= 3'h0; // partial byte dropped
			else if (cs_prev_reg || (spi_rise && spi_bit_reg == 3'h0))
				spi_tx_reg <= status_reg;
			else if (spi_rise)
				spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
			if (spi_fall) begin
				spi_rx_reg   <= {spi_rx_reg[6:0], SPI_MOSI};
				spi_bit_reg  <= spi_bit_reg + 3'h1;
				spi_done_reg <= (spi_bit_reg == 3'h7);
			end
		end
	end
	assign SPI_MISO    = spi_tx_reg[7];
	assign SPI_MISO_OE = !SPI_CS_N;

	// ==========================================================
	// command decode, uart wins a same-cycle tie
	assign cmd_in   = rx_done_reg || spi_done_reg;
	assign cmd_byte = rx_done_reg ? rx_sh_reg : spi_rx_reg;
	assign dec_ok   = !cmd_byte[0] && cmd_byte <= `CMD_FREQ_SIXTEEN;
	assign dec_sel  = cmd_byte[3:1];

	// controller: restore, execute, store, answer
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg    <= clksrc_pkg::ST_INIT;
			sel_reg      <= `SEL_RESET;
			status_reg   <= `ANS_OK;
			cmd_reg      <= `CMD_FREQ_ONE;
			cmd_uart_reg <= 1'b0;
			sel_chg      <= 1'b0;
			NV_WR_EN     <= 1'b0;
		end else begin
			sel_chg  <= 1'b0;
			NV_WR_EN <= 1'b0;
			case (state_reg)
				clksrc_pkg::ST_INIT: begin
					// stored code, or 1 MHz if not a frequency code
					if (!NV_RD_DATA[0] && NV_RD_DATA <= `CMD_FREQ_SIXTEEN)
						sel_reg <= NV_RD_DATA[3:1];
					else
						sel_reg <= `SEL_DEFAULT;
					sel_chg   <= 1'b1;
					state_reg <= clksrc_pkg::ST_IDLE;
				end
				clksrc_pkg::ST_IDLE: begin
					if (cmd_in) begin
						cmd_uart_reg <= rx_done_reg;
						if (dec_ok) begin
							cmd_reg    <= cmd_byte;
							sel_reg    <= dec_sel;
							sel_chg    <= (dec_sel != sel_reg);
							status_reg <= `ANS_BUSY;
							state_reg  <= clksrc_pkg::ST_EXEC;
						end else if (cmd_byte != `CMD_QUERY) begin
							status_reg <= `ANS_BAD;
							if (rx_done_reg)
								state_reg <= clksrc_pkg::ST_REPLY;
						end else if (rx_done_reg)
							state_reg <= clksrc_pkg::ST_REPLY;
					end
				end
				clksrc_pkg::ST_EXEC: begin
					if (NV_READY) begin
						NV_WR_EN   <= 1'b1;
						status_reg <= `ANS_OK;
						state_reg  <= cmd_uart_reg ? clksrc_pkg::ST_REPLY
						                           : clksrc_pkg::ST_IDLE;
					end
				end
				clksrc_pkg::ST_REPLY: begin
					if (tx_start)
						state_reg <= clksrc_pkg::ST_IDLE;
				end
				default: state_reg <= clksrc_pkg::ST_INIT;
			endcase
		end
	end
	assign tx_start   = (state_reg == clksrc_pkg::ST_REPLY) &&
	                    (tx_bit_reg == 4'h0);
	assign NV_WR_DATA = cmd_reg;
	assign FREQ_SEL   = sel_reg;
	assign BUSY       = (state_reg != clksrc_pkg::ST_IDLE);

	// ==========================================================
	// checks
	property p_ref_period;
		@(posedge CLOCK) disable iff (!RST_N)
		REF_TICK |=> !REF_TICK [*8];
	endproperty
	a_ref_period: assert property (p_ref_period)
		else $error("reference ticks too close");

	property p_init_default;
		@(posedge CLOCK) disable iff (!RST_N)
		(state_reg == clksrc_pkg::ST_INIT && NV_RD_DATA == 8'hff)
			|=> FREQ_SEL == 3'h0;
	endproperty
	a_init_default: assert property (p_init_default)
		else $error("invalid stored code did not give 1 MHz");

	property p_init_restore;
		@(posedge CLOCK) disable iff (!RST_N)
		(state_reg == clksrc_pkg::ST_INIT && !NV_RD_DATA[0]
			&& NV_RD_DATA <= `CMD_FREQ_SIXTEEN)
			|=> FREQ_SEL == $past(NV_RD_DATA[3:1]);
	endproperty
	a_init_restore: assert property (p_init_restore)
		else $error("stored code not applied");

	property p_store;
		@(posedge CLOCK) disable iff (!RST_N)
		NV_WR_EN |-> NV_WR_DATA[0] == 1'b0 && NV_WR_DATA <= 8'h08
			&& FREQ_SEL == NV_WR_DATA[3:1];
	endproperty
	a_store: assert property (p_store)
		else $error("stored value differs from selection");

	property p_decode;
		@(posedge CLOCK) disable iff (!RST_N)
		(state_reg == clksrc_pkg::ST_IDLE && cmd_in && dec_ok)
			|=> FREQ_SEL == $past(cmd_byte[3:1]) && status_reg == 8'h02;
	endproperty
	a_decode: assert property (p_decode)
		else $error("frequency command not decoded");

	property p_bad;
		@(posedge CLOCK) disable iff (!RST_N)
		(state_reg == clksrc_pkg::ST_IDLE && cmd_in && !dec_ok
			&& cmd_byte != 8'h0a)
			|=> status_reg == 8'h01 && $stable(FREQ_SEL) && !NV_WR_EN;
	endproperty
	a_bad: assert property (p_bad)
		else $error("unknown command changed state");

	// cycles spent waiting to answer, saturating
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			reply_wait_reg <= 16'h0000;
		else if (state_reg != clksrc_pkg::ST_REPLY)
			reply_wait_reg <= 16'h0000;
		else if (reply_wait_reg != 16'hffff)
			reply_wait_reg <= reply_wait_reg + 16'h0001;
	end

	property p_uart_reply;
		@(posedge CLOCK) disable iff (!RST_N)
		(state_reg == clksrc_pkg::ST_REPLY) |-> reply_wait_reg < `REPLY_MAX;
	endproperty
	a_uart_reply: assert property (p_uart_reply)
		else $error("no answer on uart");

	property p_tx_start;
		@(posedge CLOCK) disable iff (!RST_N)
		tx_start |=> !UART_TXD && tx_bit_reg == 4'ha;
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("answer frame did not start");

	property p_tick_rate;
		@(posedge CLOCK) disable iff (!RST_N)
		(FREQ_TICK && FREQ_SEL == 3'h0) |=> !FREQ_TICK [*8];
	endproperty
	a_tick_rate: assert property (p_tick_rate)
		else $error("1 MHz ticks too close");

	property p_baud_reload;
		@(posedge CLOCK) disable iff (!RST_N)
		sel_chg && tx_bit_reg != 4'h0 && !tx_start |=> tx_cnt_reg == baud_div;
	endproperty
	a_baud_reload: assert property (p_baud_reload)
		else $error("baud counter not reloaded");

	property p_spi_oe;
		@(posedge CLOCK) disable iff (!RST_N)
		SPI_CS_N |-> !SPI_MISO_OE;
	endproperty
	a_spi_oe: assert property (p_spi_oe)
		else $error("miso driven while deselected");

	c_uart_cmd: cover property (@(posedge CLOCK) disable iff (!RST_N)
		rx_done_reg && dec_ok);
	c_spi_cmd: cover property (@(posedge CLOCK) disable iff (!RST_N)
		spi_done_reg && dec_ok);
	c_spi_query: cover property (@(posedge CLOCK) disable iff (!RST_N)
		spi_done_reg && spi_rx_reg == 8'h0a);
	c_uart_bad: cover property (@(posedge CLOCK) disable iff (!RST_N)
		tx_start && status_reg == 8'h01);

endmodule : clksrc_core

// file: cmd_host_model.sv
// Purpose: host processor that sends one-byte commands over spi or uart
// Assumes: spi sclk idle low, data change on rise, sample on fall; uart 8N1
// Notes:   driven on the falling edge of the system clock
`timescale 1ns/1ps

module cmd_host_model (
	input  wire logic clk,
	input  wire logic miso,
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	output logic      rxd
);
	// ==========================================================
	// timing
	localparam int HALF = 4;    // clocks per sclk half bit
	localparam int BIT  = 4167; // clocks per uart bit at 4800 baud

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		rxd  = 1'b1;
	end

	// data wanders while deselected so stale bits never look valid
	always @(negedge clk) begin
		if (cs_n)
			mosi <= ~mosi;
	end

	// ==========================================================
	// one spi frame of one byte, msb first
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			@(negedge clk);
			sclk = 1'b1;
			mosi = tx[i];
			repeat (HALF) @(negedge clk);
			rx[i] = miso;
			sclk  = 1'b0;
			repeat (HALF) @(negedge clk);
		end
		repeat (HALF) @(negedge clk);
		cs_n = 1'b1;
		repeat (HALF) @(negedge clk);
	endtask : spi_byte

	// one uart frame, lsb first, one stop bit, no parity
	task automatic uart_byte(input logic [7:0] tx);
		logic [9:0] f;
		f = {1'b1, tx, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (BIT) @(negedge clk);
		end
	endtask : uart_byte
endmodule : cmd_host_model

// file: programmable_clock_command_source_test.sv
// Purpose: self-checking bench of the command driven clock source
// Assumes: 20 MHz clock; persistent memory modelled by bench inputs
// Notes:   long uart waits kept to one exchange
`timescale 1ns/1ps
`include "clksrc_defs.svh"

module programmable_clock_command_source_test;
	logic       clock, rst_n, uart_rxd, uart_txd, spi_cs_n, spi_sclk;
	logic       spi_mosi, spi_miso, spi_miso_oe, nv_ready, nv_wr_en;
	logic       freq_tick, ref_tick, busy;
	logic [7:0] nv_rd_data, nv_wr_data, rx;
	logic [2:0] freq_sel;
	int         n_fail, cmp_count, n_freq, n_ref, n_wr;

	// ==========================================================
	// design, host and clock
	clksrc_core dut (.CLOCK(clock), .RST_N(rst_n), .UART_RXD(uart_rxd),
		.UART_TXD(uart_txd), .SPI_CS_N(spi_cs_n), .SPI_SCLK(spi_sclk),
		.SPI_MOSI(spi_mosi), .SPI_MISO(spi_miso),
		.SPI_MISO_OE(spi_miso_oe), .NV_RD_DATA(nv_rd_data),
		.NV_READY(nv_ready), .NV_WR_EN(nv_wr_en), .NV_WR_DATA(nv_wr_data),
		.FREQ_TICK(freq_tick), .REF_TICK(ref_tick), .FREQ_SEL(freq_sel),
		.BUSY(busy));
	cmd_host_model host (.clk(clock), .miso(spi_miso), .cs_n(spi_cs_n),
		.sclk(spi_sclk), .mosi(spi_mosi), .rxd(uart_rxd));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// count output pulses and memory writes
	always @(posedge clock) begin
		if (freq_tick === 1'b1) n_freq++;
		if (ref_tick === 1'b1) n_ref++;
		if (nv_wr_en === 1'b1) n_wr++;
	end

	// ==========================================================
	// compare and control helpers
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8

	task automatic chkn(input string nm, input int e, input int g);
		cmp_count++;
		if (g < e - 1 || g > e + 1) begin
			n_fail++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chkn

	task automatic summarize;
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic wait_idle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 2000) begin
			@(negedge clock);
			k++;
		end
		if (busy !== 1'b0) begin
			n_fail++;
			$display("[FAIL] busy expected 0 seen %b", busy);
			summarize();
		end
		@(negedge clock); // let the last write pulse be counted
	endtask : wait_idle

	task automatic do_reset(input logic [7:0] stored);
		rst_n      = 1'b0;
		nv_rd_data = stored;
		repeat (12) @(negedge clock);
		chk8("sel in reset", 8'h04, {5'h00, freq_sel});
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
	endtask : do_reset

	// ticks over 200 cycles of 20 MHz are ten per MHz
	task automatic tick_rate(input int mhz);
		n_freq = 0;
		repeat (200) @(negedge clock);
		chkn("freq ticks", mhz * 10, n_freq);
	endtask : tick_rate

	// ==========================================================
	// scenarios
	task automatic t_default;
		do_reset(8'hff); // blank memory
		chk8("sel default", 8'h00, {5'h00, freq_sel});
		tick_rate(1);
	endtask : t_default

	task automatic t_spi_all;
		logic [7:0] code;
		for (int i = 0; i < 5; i++) begin
			code = 8'(2 * i);
			n_wr = 0;
			host.spi_byte(code, rx);
			wait_idle();
			chk8("freq_sel", 8'(i), {5'h00, freq_sel});
			chk8("nv writes", 8'h01, 8'(n_wr));
			chk8("nv data", code, nv_wr_data);
			host.spi_byte(`CMD_QUERY, rx);
			host.spi_byte(`CMD_QUERY, rx);
			chk8("spi status", `ANS_OK, rx);
			tick_rate(1 << i);
		end
	endtask : t_spi_all

	task automatic t_busy;
		nv_ready = 1'b0;
		n_wr     = 0;
		host.spi_byte(`CMD_FREQ_FOUR, rx);
		host.spi_byte(`CMD_QUERY, rx);
		chk8("status busy", `ANS_BUSY, rx);
		chk8("no write yet", 8'h00, 8'(n_wr));
		nv_ready = 1'b1;
		wait_idle();
		chk8("late write", 8'h01, 8'(n_wr));
		chk8("sel four", 8'h02, {5'h00, freq_sel});
	endtask : t_busy

	task automatic t_bad;
		logic [7:0] bad [2];
		bad = '{8'h01, 8'hff};
		for (int i = 0; i < 2; i++) begin
			n_wr = 0;
			host.spi_byte(bad[i], rx);
			wait_idle();
			host.spi_byte(`CMD_QUERY, rx);
			chk8("status bad", `ANS_BAD, rx);
			chk8("sel kept", 8'h02, {5'h00, freq_sel});
			chk8("no write", 8'h00, 8'(n_wr));
		end
	endtask : t_bad

	task automatic t_restore;
		do_reset(nv_wr_data);
		chk8("sel restored", 8'h02, {5'h00, freq_sel});
		chk8("oe idle", 8'h00, {7'h00, spi_miso_oe});
		n_ref = 0;
		repeat (10000) @(negedge clock);
		chkn("ref ticks", 16, n_ref);
	endtask : t_restore

	// unknown byte at 4 MHz: answer 01 follows on txd at 4800 baud
	task automatic t_uart;
		logic [9:0] got;
		int         k;
		k   = 0;
		got = 10'h3ff;
		fork
			host.uart_byte(8'ha5);
			begin
				while (uart_txd !== 1'b0 && k < 45000) begin
					@(negedge clock);
					k++;
				end
				if (uart_txd !== 1'b0) begin
					n_fail++;
					$display("[FAIL] tx start expected 0 seen %b", uart_txd);
					summarize();
				end
				repeat (2083) @(negedge clock);
				for (int i = 0; i < 10; i++) begin
					got[i] = uart_txd;
					if (i < 9)
						repeat (4167) @(negedge clock);
				end
			end
		join
		chk8("tx start", 8'h00, {7'h00, got[0]});
		chk8("tx answer", `ANS_BAD, got[8:1]);
		chk8("tx stop", 8'h01, {7'h00, got[9]});
		chk8("sel kept", 8'h02, {5'h00, freq_sel});
	endtask : t_uart

	// ==========================================================
	// main sequence
	initial begin
		rst_n      = 1'b0;
		nv_ready   = 1'b1;
		nv_rd_data = `CMD_FREQ_ONE;
		@(negedge clock);
		t_default();
		t_spi_all();
		t_busy();
		t_bad();
		t_restore();
		t_uart();
		summarize();
	end
endmodule : programmable_clock_command_source_test
